/* logic/ctif_defines.vh */
// Constants for the counter, timing input and terminal filter block
// Assumes a 50 MHz clock_i and a plain address/strobe register port
// Overview of operation
// - Every terminal input has its own debounce filter with its own enable bit.
// - An enabled filter samples on the fast filter clock for short/medium, slow for long.
// - A level change passes only after N consecutive samples of the new level, both ways.
// - N follows the setting: 112.5 ns, 6.4 us, 2.56 ms presets or a custom N.
// - The filtered signal carries jitter of up to one filter clock period.
// - All terminal filters are disabled after reset until software enables them.
// - Each terminal is individually set as a timing input or a timing output.
// - There are four identical 32-bit counters plus one frequency generator.
// - Each counter has eight inputs, each picked by its own selection mux.
// - Each counter owns a FIFO for buffered measurement samples.
// - Each counter has a helper counter set only through it and routed nowhere.
// - Counters never divide a timebase; the sample clock is another timing signal.
// - Implicit timing latches into the FIFO on edges of the measured signal.
// - Edge count and position take no implicit timing, semi-period no sample clocked timing.
// - Counters measure edges, pulse width, pulse, semi-period, frequency, period, position.
`ifndef CTIF_DEFINES_VH
`define CTIF_DEFINES_VH
// ==========================================
// Sizes
`define CTIF_NUM_PFT       8
`define CTIF_NUM_CTR       4
`define CTIF_FIFO_DEPTH    3'h4
// ==========================================
// Register offsets
`define CTIF_FILT_EN_OFS   8'h00
`define CTIF_FILT_SET_OFS  8'h04
`define CTIF_FILT_CUST_OFS 8'h08
`define CTIF_PFT_DIR_OFS   8'h0c
`define CTIF_PFT_OSEL_OFS  8'h10
`define CTIF_FGEN_OFS      8'h14
`define CTIF_CTR_BASE      2'h1
`define CTIF_CTR_CTRL      2'h0
`define CTIF_CTR_SEL       2'h1
`define CTIF_CTR_COUNT     2'h2
`define CTIF_CTR_FIFO      2'h3
// ==========================================
// Counter control fields
`define CTIF_F_MODE        2:0
`define CTIF_F_TIMING      4:3
`define CTIF_F_DIR         6:5
`define CTIF_B_ARM         7
`define CTIF_B_HWARM_EN    8
`define CTIF_B_PAUSE_EN    9
`define CTIF_B_PAUSE_POL   10
`define CTIF_B_SAMP_FALL   11
`define CTIF_B_SRC_FALL    12
`define CTIF_F_HELPER      23:16
`define CTIF_B_OVF_CLR     25
`define CTIF_B_OVR_CLR     27
`define CTIF_CTRL_WMASK    24'hff1fff
`define CTIF_CTRL_RST      24'h000000
// Modes and timing types
`define CTIF_M_EDGE        3'h0
`define CTIF_M_PW          3'h1
`define CTIF_M_PULSE       3'h2
`define CTIF_M_SEMI        3'h3
`define CTIF_M_FREQ        3'h4
`define CTIF_M_PERIOD      3'h5
`define CTIF_M_POS         3'h6
`define CTIF_T_DEMAND      2'h0
`define CTIF_T_IMPLICIT    2'h1
`define CTIF_T_SAMPLED     2'h2
// ==========================================
// Filter settings and timing
`define CTIF_FS_SHORT      2'h0
`define CTIF_FS_MEDIUM     2'h1
`define CTIF_FS_LONG       2'h2
`define CTIF_FS_CUSTOM     2'h3
`define CTIF_B_CUST_SLOW   16
`define CTIF_CLK_HZ        50000000
`define CTIF_CLK_PS        20000
`define CTIF_SLOW_FCLK_HZ  100000
`define CTIF_SLOW_DIV      (`CTIF_CLK_HZ / `CTIF_SLOW_FCLK_HZ)
`define CTIF_SHORT_PS      112500
`define CTIF_MEDIUM_PS     6400000
`define CTIF_LONG_NS       2560000
`define CTIF_SLOW_NS       10000
`define CTIF_N_SHORT       (`CTIF_SHORT_PS / `CTIF_CLK_PS)
`define CTIF_N_MEDIUM      (`CTIF_MEDIUM_PS / `CTIF_CLK_PS)
`define CTIF_N_LONG        (`CTIF_LONG_NS / `CTIF_SLOW_NS)
`endif

/* logic/ctif_debounce.v */
// One terminal input: two-flop synchroniser and debounce filter
// Assumes tick_i is a one-cycle filter clock enable in the clock_i domain
`timescale 1ns/1ps
module ctif_debounce (
    input  wire        clock_i,
    input  wire        reset_i,
    input  wire        pin_i,
    input  wire        enable_i,
    input  wire        tick_i,
    input  wire [15:0] n_i,
    output reg         level_o
);
    reg        sync1_reg;
    reg        sync2_reg;
    reg [15:0] cnt_reg;
    // ==========================================
    // Filter
    always @(posedge clock_i) begin
        if (reset_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            cnt_reg   <= 16'h0000;
            level_o   <= 1'b0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            if (!enable_i) begin
                cnt_reg <= 16'h0000;
                level_o <= sync2_reg;
            end else if (tick_i) begin
                if (sync2_reg == level_o) begin
                    cnt_reg <= 16'h0000;
                end else if (cnt_reg + 16'h0001 >= n_i) begin
                    cnt_reg <= 16'h0000;
                    level_o <= sync2_reg;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end
        end
    end
endmodule // ctif_debounce

/* logic/ctif_top.v */
// Four counters, frequency generator and terminal filters with register port
// Assumes pins and external timing inputs are asynchronous to clock_i
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ctif_top (
    input  wire        clock_i,
    input  wire        reset_i,
    input  wire [7:0]  addr_i,
    input  wire [31:0] wr_data_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rd_data_o,
    input  wire [7:0]  programmable_function_terminal_in_i,
    output reg  [7:0]  programmable_function_terminal_out_o,
    output reg  [7:0]  programmable_function_terminal_oe_o,
    input  wire [2:0]  ext_timing_i,
    output reg  [3:0]  counter_terminal_count_o,
    output reg  [3:0]  counter_out_o,
    output reg         freq_out_o
);
`include "ctif_defines.vh"
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_RUN  = 3'b100;
    localparam integer SLOW_LAST = `CTIF_SLOW_DIV - 1;
    localparam integer N_SH = `CTIF_N_SHORT, N_MD = `CTIF_N_MEDIUM, N_LG = `CTIF_N_LONG;

    function mux16;
        input [15:0] v;
        input [3:0]  s;
        begin
            mux16 = v[s];
        end
    endfunction

    function is_ctr_acc;
        input [7:0] a;
        input [1:0] k;
        input [1:0] r;
        begin
            is_ctr_acc = (a[7:6] == `CTIF_CTR_BASE) && (a[5:4] == k) && (a[3:2] == r);
        end
    endfunction

    // ==========================================
    // Global registers
    reg [7:0]  filt_en_reg;
    reg [15:0] filt_set_reg;
    reg [16:0] filt_cust_reg;
    reg [7:0]  pft_dir_reg;
    reg [23:0] pft_osel_reg;
    reg [16:0] fgen_reg;
    reg [15:0] fgen_cnt_reg;
    reg [8:0]  slow_cnt_reg;
    reg        slow_tick_reg;
    reg [2:0]  ext_s1_reg;
    reg [2:0]  ext_s2_reg;
    wire [7:0] pft_filt;
    wire [15:0] src_vec;
    wire [127:0] count_all;
    wire [127:0] head_all;
    wire [127:0] ctrl_rd_all;
    wire [127:0] sel_all;
    wire [3:0] tc_all;
    wire [3:0] out_all;
    wire [4:0] out_vec = {freq_out_o, counter_out_o};

    always @(posedge clock_i) begin
        if (reset_i) begin
            filt_en_reg   <= 8'h00;
            filt_set_reg  <= 16'h0000;
            filt_cust_reg <= 17'h00001;
            pft_dir_reg   <= 8'h00;
            pft_osel_reg  <= 24'h000000;
            fgen_reg      <= 17'h00000;
        end else if (wr_i) begin
            case (addr_i)
                `CTIF_FILT_EN_OFS:   filt_en_reg   <= wr_data_i[7:0];
                `CTIF_FILT_SET_OFS:  filt_set_reg  <= wr_data_i[15:0];
                `CTIF_FILT_CUST_OFS: filt_cust_reg <= wr_data_i[16:0];
                `CTIF_PFT_DIR_OFS:   pft_dir_reg   <= wr_data_i[7:0];
                `CTIF_PFT_OSEL_OFS:  pft_osel_reg  <= wr_data_i[23:0];
                `CTIF_FGEN_OFS:      fgen_reg      <= wr_data_i[16:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Slow filter clock enable and external input sync
    always @(posedge clock_i) begin
        if (reset_i) begin
            slow_cnt_reg  <= 9'h000;
            slow_tick_reg <= 1'b0;
            ext_s1_reg    <= 3'h0;
            ext_s2_reg    <= 3'h0;
        end else begin
            ext_s1_reg <= ext_timing_i;
            ext_s2_reg <= ext_s1_reg;
            slow_tick_reg <= (slow_cnt_reg == SLOW_LAST[8:0]);
            if (slow_cnt_reg == SLOW_LAST[8:0])
                slow_cnt_reg <= 9'h000;
            else
                slow_cnt_reg <= slow_cnt_reg + 9'h001;
        end
    end

    // ==========================================
    // Terminal filters and direction
    genvar p;
    generate
        for (p = 0; p < `CTIF_NUM_PFT; p = p + 1) begin : pft
            wire [1:0]  fs = filt_set_reg[2*p+1:2*p];
            wire        slow = (fs == `CTIF_FS_LONG) ||
                               (fs == `CTIF_FS_CUSTOM && filt_cust_reg[`CTIF_B_CUST_SLOW]);
            wire [15:0] n = (fs == `CTIF_FS_SHORT)  ? N_SH[15:0] :
                            (fs == `CTIF_FS_MEDIUM) ? N_MD[15:0] :
                            (fs == `CTIF_FS_LONG)   ? N_LG[15:0] :
                            filt_cust_reg[15:0];
            ctif_debounce u_flt (
                .clock_i (clock_i),
                .reset_i (reset_i),
                .pin_i   (programmable_function_terminal_in_i[p]),
                .enable_i(filt_en_reg[p]),
                .tick_i  (slow ? slow_tick_reg : 1'b1),
                .n_i     (n),
                .level_o (pft_filt[p])
            );
        end
    endgenerate

    always @(posedge clock_i) begin : pft_out
        integer i;
        if (reset_i) begin
            programmable_function_terminal_out_o <= 8'h00;
            programmable_function_terminal_oe_o  <= 8'h00;
        end else begin
            programmable_function_terminal_oe_o <= pft_dir_reg;
            for (i = 0; i < `CTIF_NUM_PFT; i = i + 1)
                programmable_function_terminal_out_o[i] <=
                    (pft_osel_reg[3*i+:3] < 3'h5) ? out_vec[pft_osel_reg[3*i+:3]] : 1'b0;
        end
    end

    // ==========================================
    // Frequency generator
    always @(posedge clock_i) begin
        if (reset_i) begin
            fgen_cnt_reg <= 16'h0000;
            freq_out_o   <= 1'b0;
        end else if (!fgen_reg[16]) begin
            fgen_cnt_reg <= 16'h0000;
            freq_out_o   <= 1'b0;
        end else if (fgen_cnt_reg + 16'h0001 >= fgen_reg[15:0]) begin
            fgen_cnt_reg <= 16'h0000;
            freq_out_o   <= ~freq_out_o;
        end else begin
            fgen_cnt_reg <= fgen_cnt_reg + 16'h0001;
        end
    end

    // No timebase enters the counter mux, only timing signals
    assign src_vec = {ext_s2_reg, freq_out_o, counter_out_o, pft_filt};

    // ==========================================
    // Counters
    genvar k;
    generate
        for (k = 0; k < `CTIF_NUM_CTR; k = k + 1) begin : ctr
            reg [23:0] ctrl_reg;
            reg [31:0] sel_reg;
            reg [2:0]  st_reg;
            reg [31:0] cnt_reg;
            reg [7:0]  helper_reg;
            reg [31:0] last_reg;
            reg        lastv_reg;
            reg        overrun_reg;
            reg        overflow_reg;
            reg        push_reg;
            reg [31:0] pval_reg;
            reg        tc_reg;
            reg        out_reg;
            reg [7:0]  prev_reg;
            reg [31:0] mem [0:3];
            reg [1:0]  wp_reg;
            reg [1:0]  rp_reg;
            reg [2:0]  lvl_reg;
            wire [7:0] in_v;
            wire [2:0] mode = ctrl_reg[`CTIF_F_MODE];
            wire [1:0] tmg = ctrl_reg[`CTIF_F_TIMING];
            wire [7:0] rise = in_v & ~prev_reg;
            wire [7:0] fall = ~in_v & prev_reg;
            wire src_e = ctrl_reg[`CTIF_B_SRC_FALL] ? fall[0] : rise[0];
            wire samp_e = ctrl_reg[`CTIF_B_SAMP_FALL] ? fall[7] : rise[7];
            wire paused = ctrl_reg[`CTIF_B_PAUSE_EN] && (in_v[1] == ctrl_reg[`CTIF_B_PAUSE_POL]);
            wire free_run = (mode == `CTIF_M_EDGE) || (mode == `CTIF_M_POS);
            wire cfg_err = ((tmg == `CTIF_T_IMPLICIT) && free_run) ||
                           ((tmg == `CTIF_T_SAMPLED) && (mode == `CTIF_M_SEMI));
            wire [7:0] hdiv = (ctrl_reg[`CTIF_F_HELPER] == 8'h00) ? 8'h01 :
                              ctrl_reg[`CTIF_F_HELPER];
            wire start_e = (mode == `CTIF_M_SEMI) ? (rise[1] | fall[1]) : rise[1];
            wire end_e = (mode == `CTIF_M_PW) ? fall[1] :
                         (mode == `CTIF_M_PULSE || mode == `CTIF_M_SEMI) ? (rise[1] | fall[1]) :
                         (mode == `CTIF_M_PERIOD) ? rise[1] :
                         (mode == `CTIF_M_FREQ) ? (rise[1] && helper_reg + 8'h01 >= hdiv) :
                         1'b0;
            wire cnt_en = (mode == `CTIF_M_PW) ? (src_e & in_v[1]) : src_e;
            wire up = (ctrl_reg[`CTIF_F_DIR] == 2'h0) ||
                      (ctrl_reg[`CTIF_F_DIR] == 2'h2 && in_v[5]);
            wire ctrl_wr = wr_i && is_ctr_acc(addr_i, k, `CTIF_CTR_CTRL);
            wire pop = rd_i && is_ctr_acc(addr_i, k, `CTIF_CTR_FIFO) && (lvl_reg != 3'h0);
            wire hw_arm = (st_reg == ST_IDLE) && ctrl_reg[`CTIF_B_HWARM_EN] && rise[3];
            genvar m;
            for (m = 0; m < 8; m = m + 1) begin : isel
                assign in_v[m] = mux16(src_vec, sel_reg[4*m+:4]);
            end

            always @(posedge clock_i) begin
                push_reg <= 1'b0;
                tc_reg   <= 1'b0;
                if (reset_i) begin
                    ctrl_reg    <= `CTIF_CTRL_RST;
                    sel_reg     <= 32'h00000000;
                    st_reg      <= ST_IDLE;
                    cnt_reg     <= 32'h00000000;
                    helper_reg  <= 8'h00;
                    last_reg    <= 32'h00000000;
                    lastv_reg   <= 1'b0;
                    overrun_reg <= 1'b0;
                    pval_reg    <= 32'h00000000;
                    out_reg     <= 1'b0;
                    prev_reg    <= 8'h00;
                end else begin
                    prev_reg <= in_v;
                    if (wr_i && is_ctr_acc(addr_i, k, `CTIF_CTR_SEL))
                        sel_reg <= wr_data_i;
                    if (ctrl_wr && wr_data_i[`CTIF_B_OVR_CLR])
                        overrun_reg <= 1'b0;
                    if (ctrl_wr || hw_arm) begin
                        if (ctrl_wr)
                            ctrl_reg <= wr_data_i[23:0] & `CTIF_CTRL_WMASK;
                        cnt_reg    <= 32'h00000000;
                        helper_reg <= 8'h00;
                        lastv_reg  <= 1'b0;
                        if (ctrl_wr && !wr_data_i[`CTIF_B_ARM])
                            st_reg <= ST_IDLE;
                        else if ((ctrl_wr ? wr_data_i[2:0] : mode) == `CTIF_M_EDGE ||
                                 (ctrl_wr ? wr_data_i[2:0] : mode) == `CTIF_M_POS)
                            st_reg <= ST_RUN;
                        else
                            st_reg <= ST_WAIT;
                    end else begin
                        case (st_reg)
                            ST_IDLE: ;
                            ST_WAIT: begin
                                if (start_e)
                                    st_reg <= ST_RUN;
                            end
                            ST_RUN: begin
                                if (mode == `CTIF_M_EDGE) begin
                                    if (src_e && !paused) begin
                                        cnt_reg <= up ? cnt_reg + 32'h00000001
                                                      : cnt_reg - 32'h00000001;
                                        if ((up && cnt_reg == 32'hffffffff) ||
                                            (!up && cnt_reg == 32'h00000000)) begin
                                            tc_reg  <= 1'b1;
                                            out_reg <= ~out_reg;
                                        end
                                    end
                                end else if (mode == `CTIF_M_POS) begin
                                    if (in_v[6])
                                        cnt_reg <= 32'h00000000;
                                    else if (rise[4])
                                        cnt_reg <= in_v[5] ? cnt_reg + 32'h00000001
                                                           : cnt_reg - 32'h00000001;
                                end else if (end_e) begin
                                    cnt_reg    <= 32'h00000000;
                                    helper_reg <= 8'h00;
                                    if (!cfg_err && tmg != `CTIF_T_SAMPLED) begin
                                        push_reg <= 1'b1;
                                        pval_reg <= cnt_reg;
                                    end
                                    if (tmg == `CTIF_T_DEMAND)
                                        st_reg <= ST_IDLE;
                                    last_reg  <= cnt_reg;
                                    lastv_reg <= 1'b1;
                                end else begin
                                    if (mode == `CTIF_M_FREQ && rise[1])
                                        helper_reg <= helper_reg + 8'h01;
                                    if (cnt_en)
                                        cnt_reg <= cnt_reg + 32'h00000001;
                                end
                            end
                            default: st_reg <= ST_IDLE;
                        endcase
                        if (tmg == `CTIF_T_SAMPLED && samp_e && st_reg != ST_IDLE &&
                            !cfg_err) begin
                            if (free_run) begin
                                push_reg <= 1'b1;
                                pval_reg <= cnt_reg;
                            end else if (lastv_reg && !end_e) begin
                                push_reg  <= 1'b1;
                                pval_reg  <= last_reg;
                                lastv_reg <= 1'b0;
                            end else if (!end_e) begin
                                overrun_reg <= 1'b1;
                            end
                        end
                    end
                end
            end

            // FIFO
            always @(posedge clock_i) begin
                if (reset_i) begin
                    wp_reg       <= 2'h0;
                    rp_reg       <= 2'h0;
                    lvl_reg      <= 3'h0;
                    overflow_reg <= 1'b0;
                end else begin
                    if (ctrl_wr && wr_data_i[`CTIF_B_OVF_CLR])
                        overflow_reg <= 1'b0;
                    if (push_reg && lvl_reg == `CTIF_FIFO_DEPTH && !pop)
                        overflow_reg <= 1'b1;
                    if (push_reg && (lvl_reg != `CTIF_FIFO_DEPTH || pop)) begin
                        mem[wp_reg] <= pval_reg;
                        wp_reg      <= wp_reg + 2'h1;
                    end
                    if (pop)
                        rp_reg <= rp_reg + 2'h1;
                    if (push_reg && (lvl_reg != `CTIF_FIFO_DEPTH || pop) && !pop)
                        lvl_reg <= lvl_reg + 3'h1;
                    else if (pop && !push_reg)
                        lvl_reg <= lvl_reg - 3'h1;
                end
            end

            assign count_all[32*k+:32]   = cnt_reg;
            assign head_all[32*k+:32]    = (lvl_reg != 3'h0) ? mem[rp_reg] : 32'h00000000;
            assign sel_all[32*k+:32]     = sel_reg;
            assign ctrl_rd_all[32*k+:32] = {1'b0, lvl_reg, overrun_reg, cfg_err,
                                            overflow_reg, st_reg != ST_IDLE, ctrl_reg};
            assign tc_all[k]  = tc_reg;
            assign out_all[k] = out_reg;
        end
    endgenerate

    // ==========================================
    // Counter outputs and read port
    always @(posedge clock_i) begin
        if (reset_i) begin
            counter_terminal_count_o <= 4'h0;
            counter_out_o            <= 4'h0;
            rd_data_o                <= 32'h00000000;
        end else begin
            counter_terminal_count_o <= tc_all;
            counter_out_o            <= out_all;
            rd_data_o                <= 32'h00000000;
            if (rd_i) begin
                if (addr_i[7:6] == `CTIF_CTR_BASE) begin
                    case (addr_i[3:2])
                        `CTIF_CTR_CTRL:  rd_data_o <= ctrl_rd_all[32*addr_i[5:4]+:32];
                        `CTIF_CTR_SEL:   rd_data_o <= sel_all[32*addr_i[5:4]+:32];
                        `CTIF_CTR_COUNT: rd_data_o <= count_all[32*addr_i[5:4]+:32];
                        default:         rd_data_o <= head_all[32*addr_i[5:4]+:32];
                    endcase
                end else begin
                    case (addr_i)
                        `CTIF_FILT_EN_OFS:   rd_data_o <= {24'h000000, filt_en_reg};
                        `CTIF_FILT_SET_OFS:  rd_data_o <= {16'h0000, filt_set_reg};
                        `CTIF_FILT_CUST_OFS: rd_data_o <= {15'h0000, filt_cust_reg};
                        `CTIF_PFT_DIR_OFS:   rd_data_o <= {16'h0000, pft_filt, pft_dir_reg};
                        `CTIF_PFT_OSEL_OFS:  rd_data_o <= {8'h00, pft_osel_reg};
                        `CTIF_FGEN_OFS:      rd_data_o <= {15'h0000, fgen_reg};
                        default:             rd_data_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end
endmodule // ctif_top

/* tb/ctif_top_props.sv */
// Checker for the counter and terminal filter block register port
// Bound to ctif_top; sees only its ports
`timescale 1ns/1ps
module ctif_top_props (
    input wire        clock_i,
    input wire        reset_i,
    input wire [7:0]  addr_i,
    input wire [31:0] wr_data_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rd_data_o,
    input wire [7:0]  programmable_function_terminal_oe_o,
    input wire [3:0]  counter_terminal_count_o
);
// ==========================================
// Properties
default clocking @(posedge clock_i); endclocking
default disable iff (reset_i);
rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data not cleared");
oe_set_a: assert property (
    wr_i && addr_i == 8'h0c
    |-> ##2 programmable_function_terminal_oe_o == $past(wr_data_i[7:0], 2))
    else $error("enable not taken");
oe_read_a: assert property (
    rd_i && addr_i == 8'h0c |=> ##1 $past(rd_data_o[7:0]) == programmable_function_terminal_oe_o)
    else $error("direction readback wrong");
fifo_lvl_a: assert property (rd_i && addr_i == 8'h40 |=> rd_data_o[30:28] <= 3'h4)
    else $error("fifo level too high");
sel_back_a: assert property (
    wr_i && addr_i == 8'h44 ##2 rd_i && addr_i == 8'h44 |=> rd_data_o == $past(wr_data_i, 3))
    else $error("select readback wrong");
ctrl_back_a: assert property (
    wr_i && addr_i == 8'h40 ##2 rd_i && addr_i == 8'h40
    |=> rd_data_o[23:0] == ($past(wr_data_i[23:0], 3) & 24'hff1fff))
    else $error("control readback wrong");
cfg_err_a: assert property (
    wr_i && addr_i == 8'h40 && wr_data_i[4:0] == 5'h08 ##2 rd_i && addr_i == 8'h40
    |=> rd_data_o[26]) else $error("config error missing");
tc_pulse_a: assert property (counter_terminal_count_o[0] |=> !counter_terminal_count_o[0])
    else $error("terminal count too long");
endmodule // ctif_top_props
bind ctif_top ctif_top_props u_props (.clock_i, .reset_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
    .rd_data_o, .programmable_function_terminal_oe_o, .counter_terminal_count_o);

/* tb/ctif_pin_model.sv */
// Far side: terminal pins and chassis timing lines
// Bench calls drive; lines change just after a rising edge
`timescale 1ns/1ps
module ctif_pin_model (
    input  wire       clock_i,
    output reg  [7:0] pins_o,
    output reg  [2:0] ext_o
);
initial {ext_o, pins_o} = 11'h0;
task drive(input [10:0] v);
    begin @(posedge clock_i); {ext_o, pins_o} <= v; end
endtask
endmodule // ctif_pin_model

/* tb/tb_top.sv */
// Bench for the counter and terminal filter block
// Assumes ctif_top with its register port and the pin model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
reg        clock_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
reg [7:0]  addr_i = 8'h0;
reg [31:0] wr_data_i = 32'h0, d;
wire [31:0] rd_data_o;
wire [7:0]  pin, pout, poe;
wire [3:0]  cout;
wire        fout;
wire [2:0]  ext;
integer    n_fail = 0, n_checks = 0;
ctif_top u_dut (.clock_i, .reset_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .programmable_function_terminal_in_i(pin), .programmable_function_terminal_out_o(pout),
    .programmable_function_terminal_oe_o(poe), .ext_timing_i(ext), .counter_terminal_count_o(),
    .counter_out_o(cout), .freq_out_o(fout));
ctif_pin_model u_p (.clock_i, .pins_o(pin), .ext_o(ext));
// ==========================================
// Bus and helper tasks
task cyc(input integer n); repeat (n) @(posedge clock_i); endtask
task wr(input [7:0] a, input [31:0] v); begin
    @(posedge clock_i); wr_i <= 1'b1; addr_i <= a; wr_data_i <= v;
    @(posedge clock_i); wr_i <= 1'b0; end
endtask
task rd(input [7:0] a); begin
    @(posedge clock_i); rd_i <= 1'b1; addr_i <= a;
    @(posedge clock_i); rd_i <= 1'b0; #1 d = rd_data_o; end
endtask
task edges(input integer n, input [10:0] m);
    repeat (n) begin u_p.drive(m); cyc(3); u_p.drive(11'h0); cyc(3); end
endtask
task stop_test; begin
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish; end
endtask
// ==========================================
// Scenarios
task t_reset; begin
    rd(8'h00); `CHK("filter enable", 32'h0, d)
    wr(8'h0c, 32'h80); rd(8'h0c); `CHK("direction", 8'h80, d[7:0])
end endtask
task t_filter; begin
    wr(8'h00, 32'h1); wr(8'h04, 32'h0);
    u_p.drive(11'h1); cyc(3); u_p.drive(11'h0); cyc(12);
    rd(8'h0c); `CHK("glitch", 1'b0, d[8])
    u_p.drive(11'h1); cyc(12); rd(8'h0c); `CHK("rise", 1'b1, d[8])
    u_p.drive(11'h0); cyc(12); rd(8'h0c); `CHK("fall", 1'b0, d[8])
    wr(8'h08, 32'h3); wr(8'h04, 32'h3);
    u_p.drive(11'h1); cyc(1); u_p.drive(11'h0); cyc(12);
    rd(8'h0c); `CHK("custom glitch", 1'b0, d[8])
    u_p.drive(11'h1); cyc(12); rd(8'h0c); `CHK("custom rise", 1'b1, d[8])
    u_p.drive(11'h0); cyc(12);
end endtask
task t_count; begin
    wr(8'h44, 32'hd0000001); rd(8'h44); `CHK("select", 32'hd0000001, d)
    wr(8'h40, 32'h80); edges(3, 11'h2); rd(8'h48); `CHK("count up", 32'h3, d)
    wr(8'h40, 32'ha0); edges(1, 11'h2); rd(8'h48); `CHK("wrap", 32'hffffffff, d)
end endtask
task t_buf; begin
    wr(8'h40, 32'h08); rd(8'h40); `CHK("config error", 1'b1, d[26])
    wr(8'h40, 32'h90); edges(2, 11'h2); edges(1, 11'h100);
    rd(8'h40); `CHK("fifo level", 3'h1, d[30:28])
    rd(8'h4c); `CHK("sample", 32'h2, d)
    rd(8'h4c); `CHK("empty fifo", 32'h0, d)
end endtask
task t_out; begin
    `CHK("counter out", 4'h1, cout)
    `CHK("terminal out", 8'hff, pout)
    `CHK("terminal enable", 8'h80, poe)
    wr(8'h10, 32'h4); wr(8'h14, 32'h10040); cyc(30); #1;
    `CHK("freq low", 2'h0, {fout, pout[0]})
    cyc(50); #1; `CHK("freq high", 2'h3, {fout, pout[0]})
    cyc(64); #1; `CHK("freq again", 2'h0, {fout, pout[0]})
end endtask
task t_pw; begin
    wr(8'h44, 32'h12); wr(8'h40, 32'h89);
    u_p.drive(11'h2); cyc(4);
    repeat (2) begin u_p.drive(11'h6); cyc(3); u_p.drive(11'h2); cyc(3); end
    u_p.drive(11'h0); cyc(6);
    rd(8'h4c); `CHK("pulse width", 32'h2, d)
end endtask
initial forever #10 clock_i = ~clock_i;
initial begin
    cyc(6); reset_i <= 1'b0;
    t_reset; t_filter; t_count; t_buf; t_out; t_pw;
    stop_test;
end
initial begin #100000; n_fail++; stop_test; end
endmodule // tb_top
